/* apc_params.svh */
// Constants for the alarm panel control logic
`ifndef APC_PARAMS_SVH
`define APC_PARAMS_SVH
`define APC_CLK_HZ 40000000
`define APC_HALF_SEC_MS 500
`define APC_HALF_SEC_CYC ((`APC_CLK_HZ / 1000) * `APC_HALF_SEC_MS)
`define APC_CANCEL_PRESSES 10
`define APC_LVL_DEFAULT 2'h1
`define APC_LVL_BACKLIGHT 2'h2
`define APC_LVL_MAX 2'h3
`define APC_KEY_NONE 4'hF
`define APC_CHAR_SLOTS 4
`endif

/* apc_pkg.sv */
// Types for the alarm panel control logic
package apc_pkg;
  typedef enum logic [1:0] {APC_SIL_IDLE, APC_SIL_ACTIVE, APC_SIL_QUIET} apc_sil_t;
endpackage

/* apc_timebase.sv */
// Shared half-second timebase for all flashing indicators
`timescale 1ns/1ps
`include "apc_params.svh"
module apc_timebase #(
  parameter int HALF_CYC = `APC_HALF_SEC_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  output logic o_phase
);
  logic [31:0] cnt_q;
  // Phase toggles every half second, giving 1 Hz with equal halves
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= 32'h0;
      o_phase <= 1'b0;
    end else if (cnt_q >= 32'(HALF_CYC - 1)) begin
      cnt_q <= 32'h0;
      o_phase <= ~o_phase;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule

/* apc_charcycle.sv */
// Multi-tap character selection for alphanumeric entry
`timescale 1ns/1ps
`include "apc_params.svh"
module apc_charcycle #(
  parameter int CHARS = `APC_CHAR_SLOTS
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_press,
  input wire logic [3:0] i_key,
  input wire logic i_alpha,
  output logic [1:0] o_index
);
  logic [3:0] last_key_q;
  // Same key steps through its letters; new key restarts at its digit
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      last_key_q <= `APC_KEY_NONE;
      o_index <= 2'h0;
    end else if (i_press) begin
      last_key_q <= i_key;
      if (i_alpha && i_key == last_key_q) begin
        o_index <= (o_index == 2'(CHARS - 1)) ? 2'h0 : o_index + 2'h1; // RULE_14
      end else begin
        o_index <= 2'h0; // RULE_14
      end
    end
  end
endmodule

/* apc_panel.sv */
// Front-panel supervisory logic for the fire panel unit
// How it works
// (RULE_01) Backlight forced on at level two up
// (RULE_02) Buzzer steady on fire, intermittent on fault
// (RULE_03) Buzzer silence at levels 1-3 stops buzzer
// (RULE_04) Alarm silence keeps external alarm device on
// (RULE_05) Second silence press resounds silenced devices
// (RULE_06) New alarm while silenced resounds all devices
// (RULE_07) Reset clears fire and system fault, needs silence
// (RULE_08) Disable needs silence, never clears fire
// (RULE_09) Alarm devices LED: disabled steady, fault flashes
// (RULE_10) Ancillary LED: disabled steady, fault flashes
// (RULE_11) Delay LED steady programmed, flashes running; override
// (RULE_12) External alarm LED: disable steady beats fault
// (RULE_13) Ten cancel presses drop to default level
// (RULE_14) Repeated key cycles digit then letters
// (RULE_15) Fire LED latched until reset, flashes evacuating
// (RULE_16) Routing LED lit, flashes 1 Hz with feedback
// (RULE_17) Mains LED lit, flashes 1 Hz on battery
// (RULE_18) System fault latches, cleared only by reset
// (RULE_19) General fault follows sources, no latch; the LED also stays lit while the latched system fault is set
// (RULE_20) Pre-alarm shown only when top condition
// (RULE_21) Disabled LED on while anything disabled
// (RULE_22) Silenced LED latched until new alarm/clear
// (RULE_23) Reset to level 1, one shared timebase
`timescale 1ns/1ps
`include "apc_params.svh"
module apc_panel
  import apc_pkg::*;
#(
  parameter int HALF_CYC = `APC_HALF_SEC_CYC,
  parameter int CANCEL_PRESSES = `APC_CANCEL_PRESSES
) (
  input wire logic I_CLOCK,
  input wire logic I_RST_N,
  input wire logic [1:0] I_LEVEL_SET,
  input wire logic I_LEVEL_LOAD,
  input wire logic I_KEY_BUZ_SIL,
  input wire logic I_KEY_ALM_SIL,
  input wire logic I_KEY_RESET,
  input wire logic I_KEY_DISABLE,
  input wire logic I_KEY_OVERRIDE,
  input wire logic I_KEY_CANCEL,
  input wire logic I_KEY_OTHER,
  input wire logic I_KEY_PAD,
  input wire logic [3:0] I_KEY_CODE,
  input wire logic I_FIELD_ALPHA,
  input wire logic I_NEW_ALARM,
  input wire logic I_EVACUATE,
  input wire logic I_FAULT_ANY,
  input wire logic I_SYS_FAIL,
  input wire logic I_ADEV_DIS,
  input wire logic I_ADEV_FLT,
  input wire logic I_ANC_DIS,
  input wire logic I_ANC_FLT,
  input wire logic I_DELAY_PROG,
  input wire logic I_DELAY_RUN,
  input wire logic I_EXT_DIS,
  input wire logic I_EXT_FLT,
  input wire logic I_ROUTE_ACT,
  input wire logic I_ROUTE_FB,
  input wire logic I_MAINS_OK,
  input wire logic I_ON_BATTERY,
  input wire logic I_ENTITY_DIS,
  input wire logic I_PREALARM,
  input wire logic I_HIGHER_ABN,
  output logic [1:0] O_LEVEL,
  output logic O_BACKLIGHT,
  output logic O_BUZZER,
  output logic O_ALM_DEV,
  output logic O_EXT_ALM,
  output logic O_DISABLE_GO,
  output logic O_DELAY_OVERRIDE,
  output logic [1:0] O_CHAR_INDEX,
  output logic O_LED_FIRE,
  output logic O_LED_ROUTE,
  output logic O_LED_MAINS,
  output logic O_LED_SYSFLT,
  output logic O_LED_FAULT,
  output logic O_LED_DISABLED,
  output logic O_LED_SILENCED,
  output logic O_LED_ADEV,
  output logic O_LED_ANC,
  output logic O_LED_DELAY,
  output logic O_LED_EXT,
  output logic O_SHOW_PREALARM
);
  logic [1:0] level_q;
  logic [3:0] cancel_cnt_q;
  logic fire_q;
  logic sysflt_q;
  logic buz_quiet_q;
  apc_sil_t sil_q;
  logic phase;
  logic intermit_q;
  logic [1:0] char_idx;
  logic lvl_ge2;
  logic reset_ok;

  // Level gate shared by most keys
  function automatic logic lvl_at_least(input logic [1:0] lv, input logic [1:0] th);
    lvl_at_least = (lv >= th);
  endfunction

  // Flashing pattern: disable steady wins over fault flash
  function automatic logic steady_or_flash(input logic st, input logic fl, input logic ph);
    steady_or_flash = st | (fl & ph);
  endfunction

  assign lvl_ge2 = lvl_at_least(level_q, `APC_LVL_BACKLIGHT);
  assign reset_ok = (sil_q == APC_SIL_QUIET) && I_KEY_RESET && lvl_ge2;

  apc_timebase #(
    .HALF_CYC(HALF_CYC)
  ) u_apc_timebase (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .o_phase(phase)
  );

  apc_charcycle #(
    .CHARS(`APC_CHAR_SLOTS)
  ) u_apc_charcycle (
    .i_clk(I_CLOCK),
    .i_rst_n(I_RST_N),
    .i_press(I_KEY_PAD && lvl_ge2),
    .i_key(I_KEY_CODE),
    .i_alpha(I_FIELD_ALPHA),
    .o_index(char_idx)
  );

  // Access level; password checks live elsewhere and load the level
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      level_q <= `APC_LVL_DEFAULT; // RULE_23
      cancel_cnt_q <= 4'h0;
    end else if (I_LEVEL_LOAD) begin
      level_q <= (I_LEVEL_SET == 2'h0) ? `APC_LVL_DEFAULT : I_LEVEL_SET;
      cancel_cnt_q <= 4'h0;
    end else if (I_KEY_CANCEL) begin
      if (cancel_cnt_q == 4'(CANCEL_PRESSES - 1)) begin
        level_q <= `APC_LVL_DEFAULT; // RULE_13
        cancel_cnt_q <= 4'h0;
      end else begin
        cancel_cnt_q <= cancel_cnt_q + 4'h1; // RULE_13
      end
    end else if (I_KEY_BUZ_SIL | I_KEY_ALM_SIL | I_KEY_RESET | I_KEY_DISABLE |
                 I_KEY_OVERRIDE | I_KEY_OTHER | I_KEY_PAD) begin
      cancel_cnt_q <= 4'h0; // Any other key breaks the run
    end
  end

  // Fire latch; new alarm sets it and wins over a same-cycle reset
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      fire_q <= 1'b0;
    end else if (I_NEW_ALARM) begin
      fire_q <= 1'b1; // RULE_15
    end else if (reset_ok) begin
      fire_q <= 1'b0; // RULE_07 RULE_08
    end
  end

  // System fault latch; only the reset key clears it
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sysflt_q <= 1'b0;
    end else if (I_SYS_FAIL) begin
      sysflt_q <= 1'b1; // RULE_18
    end else if (I_KEY_RESET && lvl_ge2 && (sil_q == APC_SIL_QUIET || !fire_q)) begin
      sysflt_q <= 1'b0; // RULE_18
    end
  end

  // Silence / resound state of the alarm devices
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      sil_q <= APC_SIL_IDLE;
    end else begin
      case (sil_q)
        APC_SIL_IDLE: begin
          if (I_NEW_ALARM) begin
            sil_q <= APC_SIL_ACTIVE;
          end
        end
        APC_SIL_ACTIVE: begin
          if (I_KEY_ALM_SIL && lvl_ge2 && !I_NEW_ALARM) begin
            sil_q <= APC_SIL_QUIET; // RULE_04
          end
        end
        APC_SIL_QUIET: begin
          if (I_NEW_ALARM) begin
            sil_q <= APC_SIL_ACTIVE; // RULE_06
          end else if (reset_ok) begin
            sil_q <= APC_SIL_IDLE; // RULE_22
          end else if (I_KEY_ALM_SIL && lvl_ge2) begin
            sil_q <= APC_SIL_ACTIVE; // RULE_05
          end
        end
        default: sil_q <= APC_SIL_IDLE;
      endcase
    end
  end

  // Buzzer silence; a new event sounds it again
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      buz_quiet_q <= 1'b0;
    end else if (I_NEW_ALARM) begin
      buz_quiet_q <= 1'b0;
    end else if (I_KEY_BUZ_SIL && level_q >= `APC_LVL_DEFAULT) begin
      buz_quiet_q <= 1'b1; // RULE_03
    end else if (!fire_q && !I_FAULT_ANY) begin
      buz_quiet_q <= 1'b0;
    end
  end

  // Intermittent fault tone reuses the half-second phase
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      intermit_q <= 1'b0;
    end else begin
      intermit_q <= phase; // RULE_23
    end
  end

  // Key-driven strobes, one cycle each
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_DISABLE_GO <= 1'b0;
      O_DELAY_OVERRIDE <= 1'b0;
    end else begin
      O_DISABLE_GO <= I_KEY_DISABLE && (level_q == `APC_LVL_BACKLIGHT) &&
                      (sil_q == APC_SIL_QUIET || !fire_q); // RULE_08
      O_DELAY_OVERRIDE <= I_KEY_OVERRIDE && lvl_ge2 && I_DELAY_RUN; // RULE_11
    end
  end

  // Registered outputs; all flashing shares the one phase
  always_ff @(posedge I_CLOCK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      O_LEVEL <= `APC_LVL_DEFAULT;
      O_BACKLIGHT <= 1'b0;
      O_BUZZER <= 1'b0;
      O_ALM_DEV <= 1'b0;
      O_EXT_ALM <= 1'b0;
      O_CHAR_INDEX <= 2'h0;
      O_LED_FIRE <= 1'b0;
      O_LED_ROUTE <= 1'b0;
      O_LED_MAINS <= 1'b0;
      O_LED_SYSFLT <= 1'b0;
      O_LED_FAULT <= 1'b0;
      O_LED_DISABLED <= 1'b0;
      O_LED_SILENCED <= 1'b0;
      O_LED_ADEV <= 1'b0;
      O_LED_ANC <= 1'b0;
      O_LED_DELAY <= 1'b0;
      O_LED_EXT <= 1'b0;
      O_SHOW_PREALARM <= 1'b0;
    end else begin
      O_LEVEL <= level_q;
      O_BACKLIGHT <= lvl_ge2; // RULE_01
      O_BUZZER <= !buz_quiet_q && (fire_q || (I_FAULT_ANY && intermit_q)); // RULE_02
      O_ALM_DEV <= (sil_q == APC_SIL_ACTIVE); // RULE_04
      O_EXT_ALM <= fire_q; // RULE_04
      O_CHAR_INDEX <= char_idx; // RULE_14
      O_LED_FIRE <= fire_q && !(I_EVACUATE && !phase); // RULE_15
      O_LED_ROUTE <= fire_q && I_ROUTE_ACT && !(I_ROUTE_FB && !phase); // RULE_16
      O_LED_MAINS <= steady_or_flash(I_MAINS_OK && !I_ON_BATTERY,
                                     I_ON_BATTERY, phase); // RULE_17
      O_LED_SYSFLT <= sysflt_q; // RULE_18
      O_LED_FAULT <= I_FAULT_ANY | sysflt_q; // RULE_19
      O_LED_DISABLED <= I_ENTITY_DIS; // RULE_21
      O_LED_SILENCED <= (sil_q == APC_SIL_QUIET); // RULE_22
      O_LED_ADEV <= steady_or_flash(I_ADEV_DIS, I_ADEV_FLT, phase); // RULE_09
      O_LED_ANC <= steady_or_flash(I_ANC_DIS, I_ANC_FLT, phase); // RULE_10
      O_LED_DELAY <= I_DELAY_RUN ? phase : I_DELAY_PROG; // RULE_11
      O_LED_EXT <= steady_or_flash(I_EXT_DIS, I_EXT_FLT, phase); // RULE_12
      O_SHOW_PREALARM <= I_PREALARM && !I_HIGHER_ABN && !fire_q; // RULE_20
    end
  end

  property p_backlight;
    @(posedge I_CLOCK) disable iff (!I_RST_N) lvl_ge2 |=> O_BACKLIGHT;
  endproperty
  a_backlight: assert property (p_backlight) else $error("backlight off"); // RULE_01

  property p_fire_buzz;
    @(posedge I_CLOCK) disable iff (!I_RST_N) (fire_q && !buz_quiet_q) |=> O_BUZZER;
  endproperty
  a_fire_buzz: assert property (p_fire_buzz) else $error("fire buzzer silent"); // RULE_02

  property p_buz_sil;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      (I_KEY_BUZ_SIL && !I_NEW_ALARM) |=> ##1 !O_BUZZER;
  endproperty
  a_buz_sil: assert property (p_buz_sil) else $error("buzzer not silenced"); // RULE_03

  property p_ext_kept;
    @(posedge I_CLOCK) disable iff (!I_RST_N) (sil_q == APC_SIL_QUIET) |=> O_EXT_ALM;
  endproperty
  a_ext_kept: assert property (p_ext_kept) else $error("ext alarm silenced"); // RULE_04

  property p_resound;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      (sil_q == APC_SIL_QUIET && I_NEW_ALARM) |=> (sil_q == APC_SIL_ACTIVE);
  endproperty
  a_resound: assert property (p_resound) else $error("no resound"); // RULE_06

  property p_reset_gate;
    @(posedge I_CLOCK) disable iff (!I_RST_N)
      (fire_q && sil_q != APC_SIL_QUIET && !I_NEW_ALARM) |=> fire_q;
  endproperty
  a_reset_gate: assert property (p_reset_gate) else $error("fire cleared unsilenced"); // RULE_07

  property p_sysflt;
    @(posedge I_CLOCK) disable iff (!I_RST_N) (sysflt_q && !I_KEY_RESET) |=> sysflt_q;
  endproperty
  a_sysflt: assert property (p_sysflt) else $error("system fault lost"); // RULE_18

  property p_fault_follow;
    @(posedge I_CLOCK) disable iff (!I_RST_N) I_FAULT_ANY |=> O_LED_FAULT;
  endproperty
  a_fault_follow: assert property (p_fault_follow) else $error("fault LED off"); // RULE_19
endmodule

/* apc_keypad_model.sv */
// Keypad and alarm event source model driving one-cycle pulses
`timescale 1ns/1ps
module apc_keypad_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_req,
  output logic [9:0] o_keys
);
  // Debounced key reaches the panel as one clock-wide pulse; bit 0 means none
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_keys <= 10'h000;
    end else begin
      o_keys <= 10'h001 << i_req;
    end
  end
endmodule

/* tb_apc_panel.sv */
// Self-checking bench for the alarm panel control logic
`timescale 1ns/1ps
module tb_apc_panel;
  localparam int HC = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] req = 4'h0;
  logic [9:0] keys;
  logic [1:0] lvl_set = 2'h0;
  logic lvl_load = 1'b0;
  logic [3:0] code = 4'h1;
  logic alpha = 1'b0;
  logic [12:0] src = 13'h0000;
  logic fault = 1'b0, sysfail = 1'b0, ent_dis = 1'b0, pre = 1'b0, higher = 1'b0;
  logic [1:0] level, chr;
  logic backl, buz, adev, ext, go, ovr, lfire, lroute, lmains, lsys, lflt;
  logic ldis, lsil, ladev, lanc, ldly, lext, lpre;
  int go_cnt = 0;
  int ovr_cnt = 0;
  logic [7:0] mon;
  int failures = 0;
  int comparisons = 0;
  logic [12:0] tsrc [9] = '{13'h00C0, 13'h0040, 13'h0020, 13'h0010, 13'h0003,
                            13'h0001, 13'h0200, 13'h0100, 13'h0000};
  int tidx [9] = '{3, 3, 2, 2, 0, 0, 4, 4, 4};
  logic [7:0] tcls [9] = '{8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h01, 8'h02, 8'h00};

  apc_keypad_model u_apc_keypad_model (.i_clk(clk), .i_rst_n(rst_n), .i_req(req), .o_keys(keys));
  apc_panel #(.HALF_CYC(HC), .CANCEL_PRESSES(10)) u_apc_panel (
    .I_CLOCK(clk), .I_RST_N(rst_n), .I_LEVEL_SET(lvl_set), .I_LEVEL_LOAD(lvl_load),
    .I_KEY_BUZ_SIL(keys[1]), .I_KEY_ALM_SIL(keys[2]), .I_KEY_RESET(keys[3]),
    .I_KEY_DISABLE(keys[4]), .I_KEY_OVERRIDE(keys[5]), .I_KEY_CANCEL(keys[6]),
    .I_KEY_OTHER(keys[7]), .I_KEY_PAD(keys[8]), .I_KEY_CODE(code), .I_FIELD_ALPHA(alpha),
    .I_NEW_ALARM(keys[9]), .I_EVACUATE(src[12]), .I_FAULT_ANY(fault), .I_SYS_FAIL(sysfail),
    .I_ADEV_DIS(src[7]), .I_ADEV_FLT(src[6]), .I_ANC_DIS(src[5]), .I_ANC_FLT(src[4]),
    .I_DELAY_PROG(src[3]), .I_DELAY_RUN(src[2]), .I_EXT_DIS(src[1]), .I_EXT_FLT(src[0]),
    .I_ROUTE_ACT(src[11]), .I_ROUTE_FB(src[10]), .I_MAINS_OK(src[9]),
    .I_ON_BATTERY(src[8]), .I_ENTITY_DIS(ent_dis), .I_PREALARM(pre), .I_HIGHER_ABN(higher),
    .O_LEVEL(level), .O_BACKLIGHT(backl), .O_BUZZER(buz), .O_ALM_DEV(adev), .O_EXT_ALM(ext),
    .O_DISABLE_GO(go), .O_DELAY_OVERRIDE(ovr), .O_CHAR_INDEX(chr), .O_LED_FIRE(lfire),
    .O_LED_ROUTE(lroute), .O_LED_MAINS(lmains), .O_LED_SYSFLT(lsys), .O_LED_FAULT(lflt),
    .O_LED_DISABLED(ldis), .O_LED_SILENCED(lsil), .O_LED_ADEV(ladev), .O_LED_ANC(lanc),
    .O_LED_DELAY(ldly), .O_LED_EXT(lext), .O_SHOW_PREALARM(lpre));
  assign mon = {buz, lfire, lroute, lmains, ladev, lanc, ldly, lext};

  // Clock and pulse counters; strobes last one cycle, so tests compare counts
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) begin
    if (go === 1'b1) go_cnt <= go_cnt + 1;
    if (ovr === 1'b1) ovr_cnt <= ovr_cnt + 1;
  end

  task automatic give_verdict;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic press(input logic [3:0] k);
    @(posedge clk);
    req <= k;
    @(posedge clk);
    req <= 4'h0;
    tick(3);
  endtask
  task automatic lvl(input logic [1:0] v);
    @(posedge clk);
    lvl_set <= v;
    lvl_load <= 1'b1;
    @(posedge clk);
    lvl_load <= 1'b0;
    tick(3);
  endtask
  task automatic set_src(input logic [12:0] v);
    @(posedge clk);
    src <= v;
    tick(3);
  endtask
  // Classifies one indicator over two flash periods: off, steady or flashing
  task automatic watch(input int idx, input logic [7:0] cls);
    int n;
    n = 0;
    repeat (16) begin
      tick(1);
      n += (mon[idx] === 1'b1);
    end
    check((n == 0) ? 8'h00 : (n == 16) ? 8'h01 : 8'h02, cls);
  endtask

  task automatic t_level;
    check({6'h00, level, backl}, 8'h02);
    lvl(2'h2);
    check({7'h00, backl}, 8'h01);
    lvl(2'h3);
    check({7'h00, backl}, 8'h01);
    lvl(2'h1);
    check({7'h00, backl}, 8'h00);
  endtask
  task automatic t_fire;
    int g0;
    lvl(2'h2);
    press(4'h9);
    check({5'h00, lfire, adev, ext}, 8'h07);
    watch(7, 8'h01);
    g0 = go_cnt;
    press(4'h3);
    press(4'h4);
    check({6'h00, lfire, (go_cnt != g0)}, 8'h02);
    press(4'h2);
    check({5'h00, adev, ext, lsil}, 8'h03);
    press(4'h2);
    check({7'h00, adev}, 8'h01);
    press(4'h2);
    press(4'h9);
    check({6'h00, adev, lsil}, 8'h02);
    set_src(13'h0800);
    watch(5, 8'h01);
    set_src(13'h0C00);
    watch(5, 8'h02);
    set_src(13'h1000);
    watch(6, 8'h02);
    set_src(13'h0000);
    press(4'h2);
    press(4'h4);
    check({6'h00, lfire, (go_cnt == g0 + 1)}, 8'h03);
    press(4'h3);
    check({6'h00, lfire, lsil}, 8'h00);
  endtask
  task automatic t_fault;
    lvl(2'h1);
    @(posedge clk);
    fault <= 1'b1;
    tick(3);
    check({7'h00, lflt}, 8'h01);
    watch(7, 8'h02);
    press(4'h1);
    watch(7, 8'h00);
    @(posedge clk);
    fault <= 1'b0;
    sysfail <= 1'b1;
    tick(3);
    @(posedge clk);
    sysfail <= 1'b0;
    tick(3);
    check({7'h00, lsys}, 8'h01);
    lvl(2'h2);
    press(4'h3);
    check({6'h00, lsys, lflt}, 8'h00);
  endtask
  task automatic t_misc;
    int o0;
    // Another key inside the run restarts the cancel count
    repeat (9) press(4'h6);
    press(4'h7);
    press(4'h6);
    press(4'h7);
    check({6'h00, level}, 8'h02);
    repeat (9) press(4'h6);
    check({6'h00, level}, 8'h02);
    press(4'h6);
    check({6'h00, level}, 8'h01);
    lvl(2'h2);
    set_src(13'h0008);
    o0 = ovr_cnt;
    press(4'h5);
    check({7'h00, (ovr_cnt != o0)}, 8'h00);
    watch(1, 8'h01);
    set_src(13'h000C);
    watch(1, 8'h02);
    press(4'h5);
    check({7'h00, (ovr_cnt == o0 + 1)}, 8'h01);
    for (int i = 0; i < 9; i++) begin
      set_src(tsrc[i]);
      watch(tidx[i], tcls[i]);
    end
    @(posedge clk);
    ent_dis <= 1'b1;
    pre <= 1'b1;
    tick(3);
    check({6'h00, ldis, lpre}, 8'h03);
    @(posedge clk);
    higher <= 1'b1;
    alpha <= 1'b1;
    tick(3);
    check({7'h00, lpre}, 8'h00);
    for (int i = 0; i < 5; i++) begin
      press(4'h8);
      check({6'h00, chr}, 8'(i % 4));
    end
    press(4'h8);
    check({6'h00, chr}, 8'h01);
    // A different key restarts at its digit
    @(posedge clk);
    code <= 4'h2;
    press(4'h8);
    check({6'h00, chr}, 8'h00);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    t_level();
    t_fire();
    t_fault();
    t_misc();
    give_verdict();
  end
  // Cuts a hang short
  initial begin
    #1000000;
    failures++;
    give_verdict();
  end
endmodule
